// *** hdl/fgas_key.sv ***
// Backdoor key comparison
`timescale 1ns/100ps
module fgas_key
	import fgas_pkg::*;
#(
	parameter int KEY_BYTES = FGAS_KEY_BYTES
)
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic key_access_in,
	input wire logic key_wr_in,
	input wire logic [2:0] key_index_in,
	input wire logic [7:0] key_data_in,
	input wire logic [8*KEY_BYTES-1:0] stored_key_in,
	output logic unlock_out
);
	import fgas_pkg::*;
	logic [3:0] count;
	logic bad;
	logic prev_wr;
	logic prev_access;

	// ----------------------------------------
	// Comparison
	// ----------------------------------------
	// Out-of-order, adjacent-cycle or wrong bytes spoil the attempt
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			count <= 4'h0;
			bad <= 1'b0;
			prev_wr <= 1'b0;
			prev_access <= 1'b0;
		end
		else
		begin
			prev_wr <= key_wr_in;
			prev_access <= key_access_in;
			if (key_access_in && !prev_access)
			begin
				count <= 4'h0;
				bad <= 1'b0;
			end
			else if (key_wr_in)
			begin
				count <= count + 4'h1;
				if (prev_wr || key_index_in != count[2:0] || count >= 4'(KEY_BYTES) ||
					key_data_in != stored_key_in[8*key_index_in +: 8])
					bad <= 1'b1;
			end
		end
	end

	// Mismatch simply produces no pulse
	assign unlock_out = prev_access && !key_access_in && !bad && count == 4'(KEY_BYTES);
endmodule

// *** hdl/fgas_pkg.sv ***
// Package: constants for the flash guard and security block
package fgas_pkg;
	// ----------------------------------------
	// Register addresses
	// ----------------------------------------
	localparam logic [15:0] FGAS_DIV_ADDR = 16'h1820;
	localparam logic [15:0] FGAS_OPT_ADDR = 16'h1821;
	localparam logic [15:0] FGAS_CFG_ADDR = 16'h1823;
	localparam logic [15:0] FGAS_PROT_ADDR = 16'h1824;
	localparam logic [15:0] FGAS_STAT_ADDR = 16'h1825;
	localparam logic [15:0] FGAS_CMD_ADDR = 16'h1826;
	localparam logic [15:0] FGAS_CTL_FIRST = 16'h1820;
	localparam logic [15:0] FGAS_CTL_LAST = 16'h1826;
	localparam logic [15:0] FGAS_NV_PROTECTION_BYTE_ADDR = 16'hffbd;
	localparam logic [15:0] FGAS_NV_OPTION_BYTE_ADDR = 16'hffbf;
	localparam logic [15:0] FGAS_KEY_ADDR = 16'hffb0;
	localparam logic [15:0] FGAS_ARRAY_BASE = 16'he000;
	localparam logic [15:0] FGAS_ARRAY_TOP = 16'hffff;
	localparam logic [15:0] FGAS_RAM_BASE = 16'h0080;
	localparam logic [15:0] FGAS_RAM_LAST = 16'h027f;
	localparam logic [15:0] FGAS_VEC_FIRST = 16'hffc0;
	localparam logic [15:0] FGAS_VEC_LAST = 16'hfffd;
	localparam int FGAS_KEY_BYTES = 8;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int FGAS_ST_CBEF = 7;
	localparam int FGAS_ST_CCF = 6;
	localparam int FGAS_ST_PVIOL = 5;
	localparam int FGAS_ST_ACCERR = 4;
	localparam int FGAS_CFG_KEY_ACCESS_BIT = 5;
	localparam int FGAS_OPT_BACKDOOR_ENABLE_BIT = 7;
	localparam int FGAS_OPT_NORED = 6;
	localparam int FGAS_PROT_DIS = 0;
	localparam int FGAS_BLOCK_BITS = 9;
	localparam logic [1:0] FGAS_SEC_OPEN = 2'b10;
	localparam logic [7:0] FGAS_PROT_RESET = 8'hff;
	localparam logic [7:0] FGAS_OPT_RESET = 8'hff;
	// ----------------------------------------
	// Command codes
	// ----------------------------------------
	localparam logic [7:0] FGAS_CMD_BLANK = 8'h05;
	localparam logic [7:0] FGAS_CMD_BYTE = 8'h20;
	localparam logic [7:0] FGAS_CMD_BURST = 8'h25;
	localparam logic [7:0] FGAS_CMD_PAGE = 8'h40;
	localparam logic [7:0] FGAS_CMD_MASS = 8'h41;
	// ----------------------------------------
	// Command sequence states
	// ----------------------------------------
	typedef enum logic [1:0] {
		FGAS_IDLE = 2'b00,
		FGAS_ARRAY = 2'b01,
		FGAS_CODE = 2'b10,
		FGAS_RUN = 2'b11
	} fgas_seq_e;
endpackage

// *** hdl/fgas_protect.sv ***
// Block protection boundary and vector redirection
`timescale 1ns/100ps
module fgas_protect
	import fgas_pkg::*;
(
	input wire logic [7:0] prot_in,
	input wire logic no_redirect_in,
	input wire logic [15:0] addr_in,
	input wire logic vector_fetch_in,
	output logic addr_protected_out,
	output logic any_protected_out,
	output logic [15:0] fetch_addr_out
);
	logic [15:0] last_unprot;
	logic prot_on;
	logic partial;
	logic in_vec;

	// ----------------------------------------
	// Boundary
	// ----------------------------------------
	assign last_unprot = {prot_in[7:1], {FGAS_BLOCK_BITS{1'b1}}};
	assign prot_on = !prot_in[FGAS_PROT_DIS];
	assign addr_protected_out = prot_on && (addr_in > last_unprot);
	assign any_protected_out = prot_on && (last_unprot != FGAS_ARRAY_TOP);
	// Whole-array protection leaves nowhere to redirect to
	assign partial = any_protected_out && (last_unprot >= FGAS_ARRAY_BASE);

	// ----------------------------------------
	// Redirection
	// ----------------------------------------
	// Reset vector lies above the range, so it is never moved
	assign in_vec = (addr_in >= FGAS_VEC_FIRST) && (addr_in <= FGAS_VEC_LAST);
	always_comb
	begin
		fetch_addr_out = addr_in;
		if (vector_fetch_in && in_vec && partial && !no_redirect_in)
			fetch_addr_out = {last_unprot[15:6], addr_in[5:0]};
	end
endmodule

// *** hdl/fgas_top.sv ***
// Flash guard: access errors, block protection, vector redirection, security
`timescale 1ns/100ps
module fgas_top
	import fgas_pkg::*;
(
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic bus_valid_in,
	input wire logic bus_write_in,
	input wire logic [15:0] bus_addr_in,
	input wire logic [7:0] bus_wdata_in,
	input wire logic bus_from_debug_in,
	input wire logic bus_secure_code_in,
	input wire logic bus_vector_fetch_in,
	output logic [7:0] bus_rdata_out,
	output logic [15:0] mem_addr_out,
	input wire logic [7:0] mem_rdata_in,
	output logic ram_write_out,
	input wire logic [7:0] nv_protection_byte_in,
	input wire logic [7:0] nv_option_byte_in,
	input wire logic [63:0] backdoor_key_bytes_in,
	output logic cmd_launch_out,
	output logic [7:0] cmd_code_out,
	output logic [15:0] cmd_addr_out,
	output logic [7:0] cmd_data_out,
	output logic cmd_abort_out,
	input wire logic cmd_done_in,
	input wire logic blank_ok_in,
	input wire logic stop_mode_in,
	input wire logic background_mode_pin_in,
	input wire logic debug_enable_req_in,
	output logic debug_enable_out,
	output logic active_background_out,
	output logic secured_out
);
	import fgas_pkg::*;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction

	function automatic logic valid_code(input logic [7:0] c);
		valid_code = c == FGAS_CMD_BLANK || c == FGAS_CMD_BYTE || c == FGAS_CMD_BURST ||
			c == FGAS_CMD_PAGE || c == FGAS_CMD_MASS;
	endfunction

	logic rst_meta;
	logic rst_n;
	logic loaded;
	logic [7:0] prot;
	logic [7:0] opt;
	logic [6:0] div;
	logic div_loaded;
	logic key_access;
	logic accerr;
	logic pviol;
	logic unlocked;
	fgas_seq_e state;
	fgas_seq_e next_state;
	logic set_err;
	logic launch;
	logic prot_hit;
	logic any_prot;
	logic unlock_key;
	logic secured;
	logic ctl_hit;
	logic arr_hit;
	logic ram_hit;
	logic ctl_wr;
	logic ctl_rd;
	logic arr_wr;
	logic key_wr;
	logic blocked;
	logic cmd_wr_ok;
	logic erase_prog_blocked;

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	assign ctl_hit = bus_valid_in && in_range(bus_addr_in, FGAS_CTL_FIRST, FGAS_CTL_LAST);
	assign arr_hit = bus_valid_in && in_range(bus_addr_in, FGAS_ARRAY_BASE, FGAS_ARRAY_TOP);
	assign ram_hit = bus_valid_in && in_range(bus_addr_in, FGAS_RAM_BASE, FGAS_RAM_LAST);
	assign ctl_wr = ctl_hit && bus_write_in;
	assign ctl_rd = ctl_hit && !bus_write_in;
	assign key_wr = arr_hit && bus_write_in && key_access && bus_secure_code_in && !bus_from_debug_in &&
		in_range(bus_addr_in, FGAS_KEY_ADDR, FGAS_KEY_ADDR + 16'h0007);
	// Key-range writes in key access mode never start a command
	assign arr_wr = arr_hit && bus_write_in && !(key_access &&
		in_range(bus_addr_in, FGAS_KEY_ADDR, FGAS_KEY_ADDR + 16'h0007));
	assign secured = !unlocked && opt[1:0] != FGAS_SEC_OPEN;
	assign blocked = secured && (bus_from_debug_in || !bus_secure_code_in);
	assign secured_out = secured;
	assign debug_enable_out = debug_enable_req_in && !secured;
	assign ram_write_out = ram_hit && bus_write_in && !blocked;

	// ----------------------------------------
	// Nonvolatile reload and option bytes
	// ----------------------------------------
	// Straps and the background pin are caught on the first clock after release
	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			loaded <= 1'b0;
			opt <= FGAS_OPT_RESET;
			active_background_out <= 1'b0;
		end
		else if (!loaded)
		begin
			loaded <= 1'b1;
			opt <= nv_option_byte_in;
			active_background_out <= !background_mode_pin_in;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
			prot <= FGAS_PROT_RESET;
		else if (!loaded)
			prot <= nv_protection_byte_in;
		else if (ctl_wr && bus_addr_in == FGAS_PROT_ADDR && bus_from_debug_in)
			prot <= bus_wdata_in;
	end

	// ----------------------------------------
	// Divider and key access
	// ----------------------------------------
	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			div <= 7'h00;
			div_loaded <= 1'b0;
		end
		else if (ctl_wr && bus_addr_in == FGAS_DIV_ADDR && !div_loaded && !accerr && state == FGAS_IDLE)
		begin
			div <= bus_wdata_in[6:0];
			div_loaded <= 1'b1;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
			key_access <= 1'b0;
		else if (ctl_wr && bus_addr_in == FGAS_CFG_ADDR && state == FGAS_IDLE)
			key_access <= bus_wdata_in[FGAS_CFG_KEY_ACCESS_BIT] && opt[FGAS_OPT_BACKDOOR_ENABLE_BIT];
	end

	// ----------------------------------------
	// Protection and key units
	// ----------------------------------------
	fgas_protect u_protect (
		.prot_in(prot),
		.no_redirect_in(opt[FGAS_OPT_NORED]),
		.addr_in(bus_addr_in),
		.vector_fetch_in(bus_vector_fetch_in),
		.addr_protected_out(),
		.any_protected_out(any_prot),
		.fetch_addr_out(mem_addr_out)
	);

	fgas_protect u_cmd_protect (
		.prot_in(prot),
		.no_redirect_in(1'b1),
		.addr_in(cmd_addr_out),
		.vector_fetch_in(1'b0),
		.addr_protected_out(prot_hit),
		.any_protected_out(),
		.fetch_addr_out()
	);

	fgas_key #(
		.KEY_BYTES(FGAS_KEY_BYTES)
	) u_key (
		.clk_in(clk_in),
		.rst_n_in(rst_n),
		.key_access_in(key_access),
		.key_wr_in(key_wr),
		.key_index_in(bus_addr_in[2:0]),
		.key_data_in(bus_wdata_in),
		.stored_key_in(backdoor_key_bytes_in),
		.unlock_out(unlock_key)
	);

	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
			unlocked <= 1'b0;
		else if ((unlock_key && opt[FGAS_OPT_BACKDOOR_ENABLE_BIT]) || blank_ok_in)
			unlocked <= 1'b1;
	end

	// ----------------------------------------
	// Command sequence checking
	// ----------------------------------------
	assign cmd_wr_ok = valid_code(bus_wdata_in) && !(bus_from_debug_in && secured &&
		(bus_wdata_in == FGAS_CMD_BYTE || bus_wdata_in == FGAS_CMD_BURST || bus_wdata_in == FGAS_CMD_PAGE));
	assign erase_prog_blocked = (cmd_code_out == FGAS_CMD_MASS) ? any_prot :
		(cmd_code_out != FGAS_CMD_BLANK && prot_hit);

	always_comb
	begin
		next_state = state;
		set_err = 1'b0;
		launch = 1'b0;
		unique case (state)
			FGAS_IDLE:
			begin
				if (arr_wr && !accerr)
				begin
					if (!div_loaded)
						set_err = 1'b1;
					else
						next_state = FGAS_ARRAY;
				end
			end
			FGAS_ARRAY:
			begin
				if (arr_wr)
					set_err = 1'b1;
				else if (ctl_wr && bus_addr_in != FGAS_CMD_ADDR)
					set_err = 1'b1;
				else if (ctl_wr && !cmd_wr_ok)
					set_err = 1'b1;
				else if (ctl_wr)
					next_state = FGAS_CODE;
			end
			FGAS_CODE:
			begin
				if (arr_wr || (ctl_wr && bus_addr_in == FGAS_CMD_ADDR))
					set_err = 1'b1;
				else if (ctl_rd || (ctl_wr && bus_addr_in != FGAS_STAT_ADDR))
					set_err = 1'b1;
				else if (ctl_wr && !bus_wdata_in[FGAS_ST_CBEF])
					set_err = 1'b1;
				else if (ctl_wr)
					launch = 1'b1;
			end
			FGAS_RUN:
			begin
				if (arr_wr)
					set_err = 1'b1;
				else if (stop_mode_in)
					set_err = 1'b1;
			end
		endcase
		if (set_err)
			next_state = FGAS_IDLE;
		else if (launch)
			next_state = erase_prog_blocked ? FGAS_IDLE : FGAS_RUN;
		else if (state == FGAS_RUN && cmd_done_in)
			next_state = FGAS_IDLE;
	end

	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
			state <= FGAS_IDLE;
		else
			state <= next_state;
	end

	// Buffer contents follow the accepted writes only
	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cmd_addr_out <= 16'h0000;
			cmd_data_out <= 8'h00;
			cmd_code_out <= 8'h00;
		end
		else if (state == FGAS_IDLE && next_state == FGAS_ARRAY)
		begin
			cmd_addr_out <= bus_addr_in;
			cmd_data_out <= bus_wdata_in;
		end
		else if (state == FGAS_ARRAY && next_state == FGAS_CODE)
			cmd_code_out <= bus_wdata_in;
	end

	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cmd_launch_out <= 1'b0;
			cmd_abort_out <= 1'b0;
		end
		else
		begin
			cmd_launch_out <= launch && !set_err && !erase_prog_blocked;
			cmd_abort_out <= state == FGAS_RUN && stop_mode_in && !arr_wr;
		end
	end

	// ----------------------------------------
	// Status flags
	// ----------------------------------------
	// Set wins over a write-one clear in the same cycle
	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			accerr <= 1'b0;
			pviol <= 1'b0;
		end
		else
		begin
			if (set_err)
				accerr <= 1'b1;
			else if (ctl_wr && bus_addr_in == FGAS_STAT_ADDR && bus_wdata_in[FGAS_ST_ACCERR])
				accerr <= 1'b0;
			if (launch && erase_prog_blocked)
				pviol <= 1'b1;
			else if (ctl_wr && bus_addr_in == FGAS_STAT_ADDR && bus_wdata_in[FGAS_ST_PVIOL])
				pviol <= 1'b0;
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
			bus_rdata_out <= 8'h00;
		else if (ctl_rd)
		begin
			unique case (bus_addr_in)
				FGAS_DIV_ADDR: bus_rdata_out <= {div_loaded, div};
				FGAS_OPT_ADDR: bus_rdata_out <= {opt[7:6], 4'h0, secured ? opt[1:0] : FGAS_SEC_OPEN};
				FGAS_CFG_ADDR: bus_rdata_out <= {2'h0, key_access, 5'h00};
				FGAS_PROT_ADDR: bus_rdata_out <= prot;
				FGAS_STAT_ADDR: bus_rdata_out <= {state != FGAS_RUN && state != FGAS_CODE && state != FGAS_ARRAY,
					state != FGAS_RUN, pviol, accerr, 4'h0};
				default: bus_rdata_out <= 8'h00;
			endcase
		end
		else if (bus_valid_in && !bus_write_in)
			bus_rdata_out <= ((arr_hit || ram_hit) && blocked) ? 8'h00 : mem_rdata_in;
	end
endmodule

// *** testbench/fgas_engine_model.sv ***
// Behavioural command engine and array read model
`timescale 1ns/100ps
module fgas_engine_model
	import fgas_pkg::*;
#(
	parameter int DELAY = 20
)
(
	input wire logic clk_in,
	input wire logic cmd_launch_in,
	input wire logic [7:0] cmd_code_in,
	input wire logic cmd_abort_in,
	input wire logic erased_in,
	input wire logic [15:0] mem_addr_in,
	output logic [7:0] mem_rdata_out,
	output logic cmd_done_out,
	output logic blank_ok_out
);
	int count = 0;
	// Data mixes both address bytes so a wrong redirect shows
	assign mem_rdata_out = mem_addr_in[7:0] ^ mem_addr_in[15:8];
	assign cmd_done_out = (count == 1);
	assign blank_ok_out = (count == 1) && erased_in && (cmd_code_in == FGAS_CMD_BLANK);
	always @(posedge clk_in)
	begin
		if (cmd_launch_in)
			count <= DELAY;
		else if (cmd_abort_in || count == 0)
			count <= 0;
		else
			count <= count - 1;
	end
endmodule

// *** testbench/fgas_monitor.sv ***
// Port checker for the flash guard block
`timescale 1ns/100ps
module fgas_monitor
	import fgas_pkg::*;
(
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic bus_valid_in,
	input wire logic bus_write_in,
	input wire logic [15:0] bus_addr_in,
	input wire logic [7:0] bus_wdata_in,
	input wire logic bus_from_debug_in,
	input wire logic bus_secure_code_in,
	input wire logic bus_vector_fetch_in,
	input wire logic [7:0] bus_rdata_out,
	input wire logic [15:0] mem_addr_out,
	input wire logic ram_write_out,
	input wire logic cmd_launch_out,
	input wire logic [7:0] cmd_code_out,
	input wire logic cmd_abort_out,
	input wire logic stop_mode_in,
	input wire logic debug_enable_req_in,
	input wire logic debug_enable_out,
	input wire logic secured_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);
	logic untrusted;
	logic launch_wr;
	assign untrusted = bus_from_debug_in | ~bus_secure_code_in;
	assign launch_wr = bus_valid_in & bus_write_in & (bus_addr_in == FGAS_STAT_ADDR) & bus_wdata_in[FGAS_ST_CBEF];
	sequence launched;
		launch_wr ##1 cmd_launch_out;
	endsequence
	sequence blocked_read;
		bus_valid_in && !bus_write_in && secured_out && untrusted && bus_addr_in >= FGAS_ARRAY_BASE;
	endsequence
	chk_launch_cause: assert property (cmd_launch_out |-> $past(launch_wr))
		else $error("launch without status write");
	chk_launch_pulse: assert property (launched |=> !cmd_launch_out)
		else $error("launch pulse too long");
	chk_launch_code: assert property (cmd_launch_out |-> cmd_code_out inside {8'h05, 8'h20, 8'h25, 8'h40, 8'h41})
		else $error("launch of invalid code");
	chk_abort_cause: assert property (cmd_abort_out |-> $past(stop_mode_in))
		else $error("abort without stop");
	chk_blocked_read: assert property (blocked_read |=> bus_rdata_out == 8'h00)
		else $error("secured read leaked data");
	chk_ram_drop: assert property (ram_write_out |-> bus_valid_in && bus_write_in && !(secured_out && untrusted))
		else $error("ram write not allowed");
	chk_debug_gate: assert property (debug_enable_out == (debug_enable_req_in && !secured_out))
		else $error("debug enable while secured");
	chk_reset_vector: assert property (bus_vector_fetch_in && bus_addr_in >= 16'hfffe |-> mem_addr_out == bus_addr_in)
		else $error("reset vector moved");
	chk_vec_offset: assert property (mem_addr_out[5:0] == bus_addr_in[5:0])
		else $error("vector offset changed");
	chk_plain_addr: assert property (!bus_vector_fetch_in |-> mem_addr_out == bus_addr_in)
		else $error("non-fetch address moved");
endmodule

bind fgas_top fgas_monitor i_mon (.clk_in(clk_in), .arst_n_in(arst_n_in), .bus_valid_in(bus_valid_in),
	.bus_write_in(bus_write_in), .bus_addr_in(bus_addr_in), .bus_wdata_in(bus_wdata_in),
	.bus_from_debug_in(bus_from_debug_in), .bus_secure_code_in(bus_secure_code_in),
	.bus_vector_fetch_in(bus_vector_fetch_in), .bus_rdata_out(bus_rdata_out), .mem_addr_out(mem_addr_out),
	.ram_write_out(ram_write_out), .cmd_launch_out(cmd_launch_out), .cmd_code_out(cmd_code_out),
	.cmd_abort_out(cmd_abort_out), .stop_mode_in(stop_mode_in), .debug_enable_req_in(debug_enable_req_in),
	.debug_enable_out(debug_enable_out), .secured_out(secured_out));

// *** testbench/tb_top.sv ***
// Self-checking bench for the flash guard block
`timescale 1ns/100ps
module tb_top;
	import fgas_pkg::*;
	logic clk_in = 1'b0;
	logic arst_n_in = 1'b0;
	logic valid = 1'b0, wr_en = 1'b0, dbg = 1'b0, sec = 1'b1, vec = 1'b0, stop = 1'b0, pin = 1'b1, dreq = 1'b0;
	logic erased = 1'b0;
	logic [15:0] addr = 16'h0000;
	logic [7:0] wdata = 8'h00, nvp = 8'hff, nvo = 8'hff;
	logic [7:0] rdo, mrd, code, cdata;
	logic [15:0] maddr, caddr;
	logic ramw, launch, abort, done, bok, dbgen, abm, secd;
	logic [63:0] key = 64'h8877665544332211;
	logic [7:0] bad_codes[3] = '{8'h00, 8'h21, 8'h42};
	logic [7:0] all_codes[5] = '{FGAS_CMD_BLANK, FGAS_CMD_BYTE, FGAS_CMD_BURST, FGAS_CMD_PAGE, FGAS_CMD_MASS};
	logic [7:0] dbg_codes[3] = '{FGAS_CMD_BYTE, FGAS_CMD_BURST, FGAS_CMD_PAGE};
	int num_errors = 0, total_checks = 0, n_launch = 0, n_abort = 0, n;
	always #5 clk_in = ~clk_in;
	always @(posedge clk_in)
	begin
		n_launch <= n_launch + int'(launch === 1'b1);
		n_abort <= n_abort + int'(abort === 1'b1);
	end
	fgas_top i_dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .bus_valid_in(valid), .bus_write_in(wr_en),
		.bus_addr_in(addr), .bus_wdata_in(wdata), .bus_from_debug_in(dbg), .bus_secure_code_in(sec),
		.bus_vector_fetch_in(vec), .bus_rdata_out(rdo), .mem_addr_out(maddr), .mem_rdata_in(mrd),
		.ram_write_out(ramw), .nv_protection_byte_in(nvp), .nv_option_byte_in(nvo), .backdoor_key_bytes_in(key),
		.cmd_launch_out(launch), .cmd_code_out(code), .cmd_addr_out(caddr), .cmd_data_out(cdata),
		.cmd_abort_out(abort), .cmd_done_in(done), .blank_ok_in(bok), .stop_mode_in(stop),
		.background_mode_pin_in(pin), .debug_enable_req_in(dreq), .debug_enable_out(dbgen),
		.active_background_out(abm), .secured_out(secd));
	fgas_engine_model i_eng (.clk_in(clk_in), .cmd_launch_in(launch), .cmd_code_in(code), .cmd_abort_in(abort),
		.erased_in(erased), .mem_addr_in(maddr), .mem_rdata_out(mrd), .cmd_done_out(done), .blank_ok_out(bok));
	// ----------------------------------------
	// Bus tasks
	// ----------------------------------------
	task automatic results();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	// One access per pulse, so back-to-back calls never land on adjacent cycles
	task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
		@(negedge clk_in);
		valid = 1'b1;
		wr_en = w;
		addr = a;
		wdata = d;
		@(negedge clk_in);
		valid = 1'b0;
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		acc(1'b1, a, d);
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		acc(1'b0, a, 8'h00);
		chk($sformatf("read %h", a), {8'h00, rdo}, {8'h00, e});
	endtask
	task automatic boot(input logic [7:0] p, input logic [7:0] o, input logic bg);
		@(negedge clk_in);
		arst_n_in = 1'b0;
		nvp = p;
		nvo = o;
		pin = bg;
		repeat (6) @(negedge clk_in);
		arst_n_in = 1'b1;
		repeat (4) @(negedge clk_in);
	endtask
	task automatic cmd(input logic [15:0] a, input logic [7:0] c);
		wr(a, 8'h5a);
		wr(FGAS_CMD_ADDR, c);
		wr(FGAS_STAT_ADDR, 8'h80);
	endtask
	task automatic idle();
		int i;
		i = 0;
		do
		begin
			acc(1'b0, FGAS_STAT_ADDR, 8'h00);
			i++;
		end
		while (rdo[FGAS_ST_CCF] !== 1'b1 && i < 40);
		if (rdo[FGAS_ST_CCF] !== 1'b1)
		begin
			num_errors++;
			results();
		end
	endtask
	task automatic err_clear();
		rd(FGAS_STAT_ADDR, 8'hd0);
		wr(FGAS_STAT_ADDR, 8'h10);
	endtask
	task automatic keys(input logic [7:0] x);
		wr(FGAS_CFG_ADDR, 8'h20);
		for (int i = 0; i < 8; i++)
			wr(FGAS_KEY_ADDR + 16'(i), key[8*i+:8] ^ x);
		wr(FGAS_CFG_ADDR, 8'h00);
		repeat (3) @(negedge clk_in);
	endtask
	initial
	begin
		repeat (20000) @(posedge clk_in);
		num_errors++;
		results();
	end
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial
	begin
		boot(8'hff, 8'hff, 1'b0);
		dreq = 1'b1;
		chk("secured", secd, 1'b1);
		chk("background", abm, 1'b1);
		chk("debug enable", dbgen, 1'b0);
		rd(FGAS_OPT_ADDR, 8'hc3);
		rd(FGAS_STAT_ADDR, 8'hc0);
		wr(16'he000, 8'h11);
		n = n_launch;
		cmd(16'he000, FGAS_CMD_BYTE);
		// A launch pulse would reach the counter one edge after the status write
		repeat (2) @(negedge clk_in);
		chk("refused launch", 16'(n_launch - n), 16'h0);
		err_clear();
		wr(FGAS_DIV_ADDR, 8'h13);
		rd(FGAS_DIV_ADDR, 8'h93);
		cmd(16'he100, FGAS_CMD_BYTE);
		rd(FGAS_STAT_ADDR, 8'h00);
		chk("code", code, FGAS_CMD_BYTE);
		chk("addr", caddr, 16'he100);
		chk("data", cdata, 8'h5a);
		wr(16'he101, 8'h00);
		idle();
		err_clear();
		wr(16'he000, 8'h00);
		wr(16'he001, 8'h00);
		err_clear();
		wr(16'he000, 8'h00);
		wr(FGAS_CMD_ADDR, FGAS_CMD_BLANK);
		wr(FGAS_CMD_ADDR, FGAS_CMD_BLANK);
		err_clear();
		wr(16'he000, 8'h00);
		wr(FGAS_CFG_ADDR, 8'h00);
		err_clear();
		foreach (bad_codes[i])
		begin
			wr(16'he000, 8'h00);
			wr(FGAS_CMD_ADDR, bad_codes[i]);
			err_clear();
		end
		wr(16'he000, 8'h00);
		wr(FGAS_CMD_ADDR, FGAS_CMD_BLANK);
		acc(1'b0, FGAS_CFG_ADDR, 8'h00);
		err_clear();
		wr(16'he000, 8'h00);
		wr(FGAS_STAT_ADDR, 8'h00);
		err_clear();
		foreach (all_codes[i])
		begin
			n = n_launch;
			cmd(16'he200, all_codes[i]);
			idle();
			chk("launch count", 16'(n_launch - n), 16'h1);
		end
		n = n_abort;
		cmd(16'he300, FGAS_CMD_BYTE);
		stop = 1'b1;
		repeat (2) @(negedge clk_in);
		stop = 1'b0;
		chk("abort count", 16'(n_abort - n), 16'h1);
		err_clear();
		sec = 1'b0;
		rd(16'he123, 8'h00);
		rd(16'h0100, 8'h00);
		wr(16'h0100, 8'h77);
		sec = 1'b1;
		rd(16'he123, 8'hc2);
		rd(16'h0100, 8'h01);
		wr(16'h0100, 8'h77);
		dbg = 1'b1;
		foreach (dbg_codes[i])
		begin
			wr(16'he000, 8'h00);
			wr(FGAS_CMD_ADDR, dbg_codes[i]);
			err_clear();
		end
		dbg = 1'b0;
		erased = 1'b1;
		cmd(16'he000, FGAS_CMD_BLANK);
		idle();
		repeat (2) @(negedge clk_in);
		chk("secured", secd, 1'b0);
		chk("debug enable", dbgen, 1'b1);
		erased = 1'b0;
		boot(8'hfc, 8'h02, 1'b1);
		chk("secured", secd, 1'b0);
		chk("background", abm, 1'b0);
		rd(FGAS_PROT_ADDR, 8'hfc);
		wr(FGAS_DIV_ADDR, 8'h13);
		vec = 1'b1;
		rd(16'hffe0, 8'h1d);
		rd(16'hfffe, 8'h01);
		vec = 1'b0;
		rd(16'hffe0, 8'h1f);
		n = n_launch;
		cmd(16'hfe10, FGAS_CMD_BYTE);
		rd(FGAS_STAT_ADDR, 8'he0);
		wr(FGAS_STAT_ADDR, 8'h20);
		cmd(16'hfdff, FGAS_CMD_BYTE);
		idle();
		chk("launch count", 16'(n_launch - n), 16'h1);
		wr(FGAS_PROT_ADDR, 8'hfd);
		rd(FGAS_PROT_ADDR, 8'hfc);
		dbg = 1'b1;
		wr(FGAS_PROT_ADDR, 8'hfd);
		dbg = 1'b0;
		rd(FGAS_PROT_ADDR, 8'hfd);
		vec = 1'b1;
		rd(16'hffe0, 8'h1f);
		vec = 1'b0;
		boot(8'hfc, 8'hc3, 1'b1);
		vec = 1'b1;
		rd(16'hffe0, 8'h1f);
		vec = 1'b0;
		keys(8'h01);
		chk("secured", secd, 1'b1);
		dbg = 1'b1;
		keys(8'h00);
		dbg = 1'b0;
		chk("secured", secd, 1'b1);
		keys(8'h00);
		chk("secured", secd, 1'b0);
		rd(FGAS_OPT_ADDR, 8'hc2);
		boot(8'hff, 8'h03, 1'b1);
		keys(8'h00);
		chk("secured", secd, 1'b1);
		results();
	end
endmodule
